// file: rtl/cdj_pkg.sv
package cdj_pkg;
    localparam int unsigned INSN_W = 14;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 7;
    localparam int unsigned PC_W = 13;
    localparam int unsigned LIT_W = 11;
    // opcode prefixes
    localparam logic [5:0] OPC_COMPLEMENT = 6'h09;
    localparam logic [5:0] OPC_DEC_SKIP = 6'h0b;
    localparam logic [2:0] OPC_JUMP = 3'h5;
    // field positions
    localparam int unsigned DEST_BIT = 7;
    localparam int unsigned LATCH_HI_BIT = 4;
    localparam int unsigned LATCH_LO_BIT = 3;
    // reset values and unit constants
    localparam logic [PC_W-1:0] PC_RESET = 13'h0000;
    localparam logic [DATA_W-1:0] ACC_RESET = 8'h00;
    localparam logic [DATA_W-1:0] DATA_ONE = 8'h01;
    localparam logic [DATA_W-1:0] DATA_ZERO = 8'h00;
    localparam logic [PC_W-1:0] PC_ONE = 13'h0001;
    typedef enum logic [1:0] {
        CDJ_EXEC,
        CDJ_FLUSH
    } cdj_state_t;
endpackage : cdj_pkg

// file: rtl/cdj_exec.sv
`timescale 1ns/1ns
`default_nettype none

// Function
// - prefix 001001 complements the addressed register
// - destination bit picks accumulator or register
// - prefix 001011 decrements the addressed register
// - decrement routes by destination, flags untouched
// - zero result discards the fetched next word
// - decrement-skip one cycle, two when skipping
// - jump loads 11-bit literal into pc low
// - pc bits 12:11 from latch bits 4:3
// - jump always taken, two cycles, no flags
module cdj_exec
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [13:0] i_insn,
    input wire logic i_insn_valid,
    input wire logic [7:0] i_file_rdata,
    input wire logic [7:0] i_upper_latch,
    input wire logic i_zero_flag,
    output logic [6:0] o_file_addr,
    output logic [7:0] o_file_wdata,
    output logic o_file_we,
    output logic [7:0] o_acc,
    output logic o_zero_flag,
    output logic o_zero_we,
    output logic [12:0] o_pc,
    output logic o_flush,
    output logic o_busy
);

    ////////////////////////////////////////////////////////////////////////
    // decode

    cdj_pkg::cdj_state_t state_r;
    cdj_pkg::cdj_state_t state_nxt;
    logic [7:0] acc_r;
    logic [7:0] acc_nxt;
    logic [12:0] pc_r;
    logic [12:0] pc_nxt;
    logic [7:0] wdata_r;
    logic we_r;
    logic zf_r;
    logic zwe_r;

    wire logic executing;
    wire logic is_comp;
    wire logic is_decsk;
    wire logic is_jump;
    wire logic dest_file;
    wire logic [7:0] comp_res;
    wire logic [7:0] dec_res;
    wire logic [7:0] alu_res;
    wire logic dec_zero;
    wire logic [12:0] jump_target;
    wire logic [10:0] jump_low;
    wire logic [1:0] jump_high;
    wire logic writes_result;
    wire logic acc_load;
    wire logic skip_taken;
    wire logic is_flush;
    wire logic [12:0] pc_seq;
    wire logic we_nxt;
    wire logic zf_nxt;
    wire logic zwe_nxt;

    ////////////////////////////////////////////////////////////////////////
    // helpers

    // both file-register operations decode the same six-bit prefix field
    function automatic logic [5:0] op_prefix(input logic [13:0] insn);
        op_prefix = insn[13:8];
    endfunction : op_prefix

    // sequential step, shared by plain execute, skip and the no-op cycle
    function automatic logic [12:0] pc_step(input logic [12:0] pc);
        pc_step = pc + cdj_pkg::PC_ONE;
    endfunction : pc_step

    // zero test for both the skip decision and the complement flag
    function automatic logic is_zero(input logic [7:0] value);
        is_zero = (value == cdj_pkg::DATA_ZERO);
    endfunction : is_zero

    assign executing = i_insn_valid && (state_r == cdj_pkg::CDJ_EXEC);
    assign is_comp = executing && (op_prefix(i_insn) == cdj_pkg::OPC_COMPLEMENT);
    assign is_decsk = executing && (op_prefix(i_insn) == cdj_pkg::OPC_DEC_SKIP);
    assign is_jump = executing && (i_insn[13:11] == cdj_pkg::OPC_JUMP);
    assign dest_file = i_insn[cdj_pkg::DEST_BIT];
    assign comp_res = ~i_file_rdata;
    assign dec_res = i_file_rdata - cdj_pkg::DATA_ONE;
    assign alu_res = is_comp ? comp_res : dec_res;
    assign dec_zero = is_zero(dec_res);
    assign writes_result = is_comp || is_decsk;
    assign acc_load = writes_result && !dest_file;
    // zero after decrement drops the fetched word
    assign skip_taken = is_decsk && dec_zero;
    assign is_flush = (state_r == cdj_pkg::CDJ_FLUSH);
    assign pc_seq = pc_step(pc_r);
    assign jump_low = i_insn[10:0];
    assign jump_high = i_upper_latch[cdj_pkg::LATCH_HI_BIT:cdj_pkg::LATCH_LO_BIT];
    assign jump_target = {jump_high, jump_low};
    assign o_file_addr = i_insn[6:0];

    ////////////////////////////////////////////////////////////////////////
    // write-back values

    assign we_nxt = writes_result && dest_file;
    assign zf_nxt = is_comp ? is_zero(comp_res) : i_zero_flag;
    // a jump never raises the flag strobe
    assign zwe_nxt = is_comp;

    ////////////////////////////////////////////////////////////////////////
    // next state

    always_comb
    begin
        state_nxt = cdj_pkg::CDJ_EXEC;
        acc_nxt = acc_r;
        pc_nxt = pc_r;
        if (acc_load)
        begin
            acc_nxt = alu_res;
        end
        unique case (state_r)
            cdj_pkg::CDJ_FLUSH:
            begin
                // second cycle runs as a no-op
                pc_nxt = pc_seq;
            end
            cdj_pkg::CDJ_EXEC:
            begin
                if (is_jump)
                begin
                    // always taken, spend a second cycle
                    pc_nxt = jump_target;
                    state_nxt = cdj_pkg::CDJ_FLUSH;
                end
                else if (skip_taken)
                begin
                    pc_nxt = pc_seq;
                    state_nxt = cdj_pkg::CDJ_FLUSH;
                end
                else if (executing)
                begin
                    pc_nxt = pc_seq;
                end
            end
            default:
            begin
                // spare encodings fall back to execute
                state_nxt = cdj_pkg::CDJ_EXEC;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // registers

    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            state_r <= cdj_pkg::CDJ_EXEC;
            acc_r <= cdj_pkg::ACC_RESET;
            pc_r <= cdj_pkg::PC_RESET;
        end
        else
        begin
            state_r <= state_nxt;
            acc_r <= acc_nxt;
            pc_r <= pc_nxt;
        end
    end

    // write-back held one cycle so the data output comes from flops
    always_ff @(posedge i_clk_sys or negedge i_rst_b)
    begin
        if (!i_rst_b)
        begin
            wdata_r <= cdj_pkg::DATA_ZERO;
            we_r <= 1'b0;
            zf_r <= 1'b0;
            zwe_r <= 1'b0;
        end
        else
        begin
            wdata_r <= alu_res;
            we_r <= we_nxt;
            zf_r <= zf_nxt;
            zwe_r <= zwe_nxt;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs

    assign o_file_wdata = wdata_r;
    assign o_file_we = we_r;
    assign o_acc = acc_r;
    assign o_zero_flag = zf_r;
    assign o_zero_we = zwe_r;
    assign o_pc = pc_r;
    // flush marks the no-op cycle
    // shown outside so fetch can drop the word it already holds
    assign o_flush = is_flush;
    assign o_busy = is_flush;

endmodule : cdj_exec

`default_nettype wire

// file: testbench/cdj_exec_sva.sv
`timescale 1ns/1ns
`default_nettype none
module cdj_chk
(
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic [13:0] i_insn,
    input wire logic i_insn_valid,
    input wire logic [7:0] i_file_rdata,
    input wire logic [7:0] i_upper_latch,
    input wire logic [7:0] o_file_wdata,
    input wire logic o_file_we,
    input wire logic [7:0] o_acc,
    input wire logic o_zero_flag,
    input wire logic o_zero_we,
    input wire logic [12:0] o_pc,
    input wire logic o_flush
);
    // a word offered in the flush cycle is the discarded one
    wire tk = i_insn_valid & ~o_flush;
    wire cm = tk && i_insn[13:8] == 6'h09;
    wire dc = tk && i_insn[13:8] == 6'h0b;
    wire jp = tk && i_insn[13:11] == 3'h5;
    default clocking @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    sequence s_lost;
        o_flush ##1 !o_flush;
    endsequence
    a_comp_acc: assert property (cm && !i_insn[7] |=> o_acc == ~$past(i_file_rdata) && !o_file_we)
        else $error("complement to acc wrong");
    a_comp_reg: assert property (cm && i_insn[7] |=> o_file_we && o_file_wdata == ~$past(i_file_rdata))
        else $error("complement to reg wrong");
    a_comp_zero: assert property (cm |=> o_zero_we && o_zero_flag == ($past(i_file_rdata) == 8'hff))
        else $error("complement zero wrong");
    a_dec_reg: assert property (dc && i_insn[7] |=> o_file_we && o_file_wdata == $past(i_file_rdata) - 8'h01)
        else $error("decrement wrong");
    a_dec_flags: assert property (dc |=> !o_zero_we)
        else $error("decrement wrote flag");
    a_skip_taken: assert property (dc && i_file_rdata == 8'h01 |=> s_lost)
        else $error("skip missing");
    a_skip_none: assert property (dc && i_file_rdata != 8'h01 |=> !o_flush)
        else $error("skip spurious");
    a_jump_pc: assert property (jp |=> s_lost and o_pc == {$past(i_upper_latch[4:3]), $past(i_insn[10:0])})
        else $error("jump target wrong");
    a_jump_flags: assert property (jp |=> !o_zero_we && !o_file_we)
        else $error("jump wrote a flag");
    a_dec_acc: assert property (dc && !i_insn[7] |=> o_acc == $past(i_file_rdata) - 8'h01 && !o_file_we)
        else $error("decrement to acc wrong");
    a_flush_quiet: assert property (o_flush |=> !o_file_we && !o_zero_we && $stable(o_acc))
        else $error("discarded word took effect");
endmodule : cdj_chk
bind cdj_exec cdj_chk i_chk (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_insn(i_insn),
    .i_insn_valid(i_insn_valid), .i_file_rdata(i_file_rdata), .i_upper_latch(i_upper_latch),
    .o_file_wdata(o_file_wdata), .o_file_we(o_file_we), .o_acc(o_acc), .o_zero_flag(o_zero_flag),
    .o_zero_we(o_zero_we), .o_pc(o_pc), .o_flush(o_flush));
`default_nettype wire

// file: testbench/test_complement_decskip_jump_exec.sv
`timescale 1ns/1ns
`default_nettype none
module test_complement_decskip_jump_exec;
    logic i_clk_sys = 1'h0, i_rst_b = 1'h0, i_insn_valid = 1'h0, i_zero_flag = 1'h0;
    logic [13:0] i_insn = 14'h0000;
    logic [7:0] i_file_rdata = 8'h00, i_upper_latch = 8'h00, o_file_wdata, o_acc;
    logic [6:0] o_file_addr;
    logic o_file_we, o_zero_flag, o_zero_we, o_flush, o_busy;
    logic [12:0] o_pc, pc0;
    int bad_count = 0, tests_run = 0, cyc = 0;
    cdj_exec i_dut (.i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_insn(i_insn), .i_insn_valid(i_insn_valid),
        .i_file_rdata(i_file_rdata), .i_upper_latch(i_upper_latch), .i_zero_flag(i_zero_flag),
        .o_file_addr(o_file_addr), .o_file_wdata(o_file_wdata), .o_file_we(o_file_we), .o_acc(o_acc),
        .o_zero_flag(o_zero_flag), .o_zero_we(o_zero_we), .o_pc(o_pc), .o_flush(o_flush), .o_busy(o_busy));
    ////////////////////////////////////////
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            bad_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    // one idle edge between words keeps each result apart
    task run(input logic [13:0] w, input logic [7:0] r);
        @(posedge i_clk_sys);
        i_insn <= w;
        i_file_rdata <= r;
        i_insn_valid <= 1'h1;
        #1 pc0 = o_pc;
        @(posedge i_clk_sys);
        i_insn_valid <= 1'h0;
        #1;
    endtask : run
    task t_comp;
        run(14'h0913, 8'h13);
        chk({o_acc, o_zero_we, o_zero_flag, o_file_we}, 11'h764);
        chk(o_file_addr, 7'h13);
        chk(o_pc, pc0 + 13'h0001);
        run(14'h0993, 8'hff);
        chk({o_file_we, o_file_wdata, o_zero_flag, o_acc}, 18'h201ec);
    endtask : t_comp
    task t_dec;
        run(14'h0b93, 8'h05);
        chk({o_file_we, o_file_wdata, o_zero_we, o_flush}, 11'h410);
        run(14'h0b13, 8'h01);
        chk({o_acc, o_flush, o_busy, o_file_we}, 11'h006);
        @(posedge i_clk_sys);
        #1;
        chk({o_flush, o_pc}, {1'h0, pc0 + 13'h0002});
    endtask : t_dec
    task t_jump;
        @(posedge i_clk_sys);
        i_upper_latch <= 8'h18;
        i_insn <= 14'h2da5;
        i_insn_valid <= 1'h1;
        @(posedge i_clk_sys);
        i_insn <= 14'h0913;
        #1;
        chk({o_flush, o_pc}, 14'h3da5);
        @(posedge i_clk_sys);
        i_insn_valid <= 1'h0;
        #1;
        chk({o_acc, o_zero_we, o_pc}, {8'h00, 1'h0, 13'h1da6});
    endtask : t_jump
    // reset lands in the no-op cycle of a taken skip
    task t_reset;
        run(14'h0913, 8'h13);
        @(posedge i_clk_sys);
        i_insn <= 14'h0b93;
        i_file_rdata <= 8'h01;
        i_insn_valid <= 1'h1;
        @(posedge i_clk_sys);
        i_insn_valid <= 1'h0;
        i_rst_b <= 1'h0;
        #1;
        chk({o_acc, o_flush, o_file_we, o_pc}, 23'h000000);
        @(posedge i_clk_sys);
        i_rst_b <= 1'h1;
        run(14'h0913, 8'h13);
        chk({o_acc, o_pc}, {8'hec, 13'h0001});
    endtask : t_reset
    task results;
        if (bad_count == 0 && tests_run > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : results
    initial
    begin
        forever #50 i_clk_sys = ~i_clk_sys;
    end
    always @(posedge i_clk_sys)
    begin
        cyc++;
        if (cyc == 500)
        begin
            bad_count++;
            results();
        end
    end
    initial
    begin
        repeat (20) @(posedge i_clk_sys);
        i_rst_b <= 1'h1;
        t_comp();
        t_dec();
        t_jump();
        t_reset();
        results();
    end
endmodule : test_complement_decskip_jump_exec
`default_nettype wire
